//--- dpfa_flash_model.sv
// Flash array model answering promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module dpfa_flash_model (
   input  wire logic                    sys_clk, rstn, slow,
   input  wire logic [1:0]              ecc,
   input  wire dpfa_pkg::dpfa_arr_req_t arr_req,
   output logic                         arr_ready,
   output dpfa_pkg::dpfa_arr_rsp_t      arr_rsp
);
   logic        busy;
   logic [2:0]  cnt;
   logic [23:0] addr;
   assign arr_ready = rstn && !busy && !arr_rsp.valid;
   always @(posedge sys_clk) begin
      // Data is junk that changes every cycle outside reset and the result pulse
      arr_rsp <= '{1'b0, ~arr_rsp.data, 1'b0, 1'b0};
      if (!rstn) begin
         busy <= 1'b0;
         arr_rsp <= '0;
      end else if (arr_req.valid && arr_ready) begin
         busy <= 1'b1;
         cnt <= slow ? 3'h6 : 3'h0;
         addr <= arr_req.addr;
      end else if (busy && cnt != 3'h0) cnt <= cnt - 3'h1;
      else if (busy) begin
         busy <= 1'b0;
         arr_rsp <= '{1'b1, {40'h0, addr}, ecc[1], ecc[0]};
      end
   end
endmodule
`default_nettype wire

//--- dpfa_params.svh
// Constants of the dual port flash arbiter
`ifndef DPFA_PARAMS_SVH
`define DPFA_PARAMS_SVH
`define DPFA_ADDR_W       24
`define DPFA_DATA_W       64
`define DPFA_MID_W        3
`define DPFA_CORE_PORT    1'h0
`define DPFA_SHARED_PORT  1'h1
`define DPFA_CORE_SLAVE   3'h0
`define DPFA_SHARED_SLAVE 3'h3
`define DPFA_CORE_MASK    8'h03
`define DPFA_SHARED_MASK  8'hFC
`define DPFA_RR_RESET     1'h0
`endif

//--- dpfa_pkg.sv
// Types of the dual port flash arbiter
`include "dpfa_params.svh"
package dpfa_pkg;
   typedef enum logic [0:0] {
      DPFA_MODE_FIXED = 1'b0,
      DPFA_MODE_RR    = 1'b1
   } dpfa_mode_t;

   typedef struct packed {
      logic                      valid;
      logic [`DPFA_MID_W-1:0]    master;
      logic [`DPFA_ADDR_W-1:0]   addr;
   } dpfa_req_t;

   typedef struct packed {
      logic                      valid;
      logic                      error;
      logic [`DPFA_DATA_W-1:0]   data;
   } dpfa_rsp_t;

   typedef struct packed {
      logic                      valid;
      logic                      port;
      logic [`DPFA_ADDR_W-1:0]   addr;
   } dpfa_arr_req_t;

   typedef struct packed {
      logic                      valid;
      logic [`DPFA_DATA_W-1:0]   data;
      logic                      ecc_multi;
      logic                      ecc_addr;
   } dpfa_arr_rsp_t;
endpackage

//--- dpfa_port.sv
// One crossbar slave port of the flash arbiter: admission and holding register
`timescale 1ns/1ps
`default_nettype none
`include "dpfa_params.svh"
module dpfa_port #(
   parameter logic [7:0] ALLOW = 8'hFF
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   // Crossbar side
   input  wire dpfa_pkg::dpfa_req_t req,
   output logic                    req_ready,
   // Arbiter side
   output logic                    pending,
   output dpfa_pkg::dpfa_req_t     held,
   input  wire logic               grant,
   output logic                    refused
);
   logic allowed;
   logic take;

   assign allowed   = ALLOW[req.master];
   assign req_ready = ~pending;
   assign take      = req.valid & req_ready & allowed;
   assign refused   = req.valid & req_ready & ~allowed;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pending <= 1'h0;
         held    <= '0;
      end else if (take) begin
         pending <= 1'h1;
         held    <= req;
      end else if (grant) begin
         pending <= 1'h0;
      end
   end
endmodule
`default_nettype wire

//--- dpfa_top.sv
// Dual port flash arbiter: two crossbar slave ports sharing one flash array
//
// Overview of operation
// - Two independent read ports share one array
// - Core-only port admits first core masters only
// - Shared port admits all other masters
// - Mode input picks round-robin or fixed priority
// - Fixed mode grants higher-priority port on collision
// - Round-robin alternates grants under contention
// - ECC address and multi-bit errors flagged
// - Core-only port is slave zero, masters 0-1
// - Shared port is slave three, masters 2-7
`timescale 1ns/1ps
`default_nettype none
`include "dpfa_params.svh"
module dpfa_top (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   // Configuration
   input  wire dpfa_pkg::dpfa_mode_t arb_mode,
   input  wire logic                 hi_prio_port,
   // Core-only port (crossbar slave 0)
   input  wire dpfa_pkg::dpfa_req_t  core_req,
   output logic                      core_ready,
   output dpfa_pkg::dpfa_rsp_t       core_rsp,
   // Shared port (crossbar slave 3)
   input  wire dpfa_pkg::dpfa_req_t  shr_req,
   output logic                      shr_ready,
   output dpfa_pkg::dpfa_rsp_t       shr_rsp,
   // Flash array
   output dpfa_pkg::dpfa_arr_req_t   arr_req,
   input  wire logic                 arr_ready,
   input  wire dpfa_pkg::dpfa_arr_rsp_t arr_rsp
);
   logic                core_pend;
   logic                shr_pend;
   dpfa_pkg::dpfa_req_t core_held;
   dpfa_pkg::dpfa_req_t shr_held;
   logic                core_refused;
   logic                shr_refused;
   logic                core_grant;
   logic                shr_grant;
   logic                busy;
   logic                owner;
   logic                rr_turn;
   logic                both;
   logic                pick;
   logic                issue;
   dpfa_pkg::dpfa_rsp_t next_core_rsp;
   dpfa_pkg::dpfa_rsp_t next_shr_rsp;
   logic                rsp_err;

   // Masters 0 and 1 only reach slave 0
   dpfa_port #(.ALLOW(`DPFA_CORE_MASK)) u_core (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .req       (core_req),
      .req_ready (core_ready),
      .pending   (core_pend),
      .held      (core_held),
      .grant     (core_grant),
      .refused   (core_refused)
   );

   // Masters 2 through 7 reach slave 3
   dpfa_port #(.ALLOW(`DPFA_SHARED_MASK)) u_shr (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .req       (shr_req),
      .req_ready (shr_ready),
      .pending   (shr_pend),
      .held      (shr_held),
      .grant     (shr_grant),
      .refused   (shr_refused)
   );

   // One read in flight at a time; the array is single ported
   assign both  = core_pend & shr_pend;
   assign pick  = !both ? shr_pend :
                  (arb_mode == dpfa_pkg::DPFA_MODE_RR) ? rr_turn :
                  hi_prio_port;
   assign issue = ~busy & (core_pend | shr_pend) & arr_ready;
   assign core_grant = issue & (pick == `DPFA_CORE_PORT);
   assign shr_grant  = issue & (pick == `DPFA_SHARED_PORT);

   assign arr_req.valid = ~busy & (core_pend | shr_pend);
   assign arr_req.port  = pick;
   assign arr_req.addr  = (pick == `DPFA_SHARED_PORT) ? shr_held.addr : core_held.addr;

   // Address and multi-bit faults are both uncorrectable
   assign rsp_err = arr_rsp.ecc_multi | arr_rsp.ecc_addr;

   // Refused masters get an immediate error so they never hang
   always_comb begin
      next_core_rsp       = '0;
      next_shr_rsp        = '0;
      next_core_rsp.data  = arr_rsp.data;
      next_shr_rsp.data   = arr_rsp.data;
      if (busy && arr_rsp.valid) begin
         if (owner == `DPFA_SHARED_PORT) begin
            next_shr_rsp.valid = 1'h1;
            next_shr_rsp.error = rsp_err;
         end else begin
            next_core_rsp.valid = 1'h1;
            next_core_rsp.error = rsp_err;
         end
      end
      if (core_refused) begin
         next_core_rsp.valid = 1'h1;
         next_core_rsp.error = 1'h1;
         next_core_rsp.data  = '0;
      end
      if (shr_refused) begin
         next_shr_rsp.valid = 1'h1;
         next_shr_rsp.error = 1'h1;
         next_shr_rsp.data  = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         busy     <= 1'h0;
         owner    <= 1'h0;
         rr_turn  <= `DPFA_RR_RESET;
         core_rsp <= '0;
         shr_rsp  <= '0;
      end else begin
         core_rsp <= next_core_rsp;
         shr_rsp  <= next_shr_rsp;
         if (issue) begin
            busy  <= 1'h1;
            owner <= pick;
            // Turn passes to the other port after each grant
            rr_turn <= ~pick;
         end else if (busy && arr_rsp.valid) begin
            busy <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

//--- dpfa_top_asserts.sv
// Port assertions for the flash arbiter
`timescale 1ns/1ps
`default_nettype none
module dpfa_top_asserts (
   input wire logic                    sys_clk, rstn, hi_prio_port, core_ready, shr_ready, arr_ready,
   input wire dpfa_pkg::dpfa_mode_t    arb_mode,
   input wire dpfa_pkg::dpfa_req_t     core_req, shr_req,
   input wire dpfa_pkg::dpfa_rsp_t     core_rsp, shr_rsp,
   input wire dpfa_pkg::dpfa_arr_req_t arr_req,
   input wire dpfa_pkg::dpfa_arr_rsp_t arr_rsp
);
   logic turn;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Turn goes to the port not granted last
   always_ff @(posedge sys_clk) begin
      if (!rstn) turn <= 1'b0;
      else if (arr_req.valid && arr_ready) turn <= !arr_req.port;
   end
   // Both ports held when the array request first rises
   sequence s_clash;
      arr_req.valid && !core_ready && !shr_ready && !$past(arr_req.valid);
   endsequence
   AST_CORE_REFUSE: assert property (
      core_req.valid && core_ready && core_req.master > 3'h1 |=> core_rsp.valid && core_rsp.error)
      else $error("core port took another master");
   AST_SHR_REFUSE: assert property (
      shr_req.valid && shr_ready && shr_req.master < 3'h2 |=> shr_rsp.valid && shr_rsp.error)
      else $error("shared port took a core master");
   AST_CORE_TAKE: assert property (
      core_req.valid && core_ready && core_req.master < 3'h2 |=> !core_ready && arr_req.valid)
      else $error("core request not held");
   AST_SHR_TAKE: assert property (
      shr_req.valid && shr_ready && shr_req.master > 3'h1 |=> !shr_ready && arr_req.valid)
      else $error("shared request not held");
   AST_ARR_HOLD: assert property (arr_req.valid && !arr_ready |=> $stable(arr_req))
      else $error("array request changed while waiting");
   AST_ECC: assert property (arr_rsp.valid |=> (core_rsp.valid || shr_rsp.valid) &&
      (core_rsp.error || shr_rsp.error) == $past(arr_rsp.ecc_multi || arr_rsp.ecc_addr))
      else $error("array result lost or error flag wrong");
   AST_FIX: assert property (s_clash |-> arb_mode == dpfa_pkg::DPFA_MODE_RR || arr_req.port == hi_prio_port)
      else $error("fixed priority lost");
   AST_RR: assert property (s_clash |-> arb_mode == dpfa_pkg::DPFA_MODE_FIXED || arr_req.port == turn)
      else $error("round robin turn lost");
endmodule
bind dpfa_top dpfa_top_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn), .hi_prio_port(hi_prio_port),
   .core_ready(core_ready), .shr_ready(shr_ready), .arr_ready(arr_ready), .arb_mode(arb_mode),
   .core_req(core_req), .shr_req(shr_req), .core_rsp(core_rsp), .shr_rsp(shr_rsp),
   .arr_req(arr_req), .arr_rsp(arr_rsp));
`default_nettype wire

//--- dpfa_top_test.sv
// Self-checking bench for the flash arbiter
`timescale 1ns/1ps
`default_nettype none
module dpfa_top_test;
   logic                    sys_clk = 0, rstn = 0, hi_prio_port = 0, slow = 0, last_p, arr_ready, rdy [2];
   logic [1:0]              ecc = 0;
   dpfa_pkg::dpfa_mode_t    arb_mode = dpfa_pkg::DPFA_MODE_FIXED;
   dpfa_pkg::dpfa_req_t     req [2] = '{'0, '0};
   dpfa_pkg::dpfa_rsp_t     rsp [2];
   dpfa_pkg::dpfa_arr_req_t arr_req;
   dpfa_pkg::dpfa_arr_rsp_t arr_rsp;
   int                      bad_count = 0, samples_checked = 0;
   always #12.5 sys_clk = ~sys_clk;
   dpfa_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .arb_mode(arb_mode), .hi_prio_port(hi_prio_port),
      .core_req(req[0]), .core_ready(rdy[0]), .core_rsp(rsp[0]), .shr_req(req[1]), .shr_ready(rdy[1]),
      .shr_rsp(rsp[1]), .arr_req(arr_req), .arr_ready(arr_ready), .arr_rsp(arr_rsp));
   dpfa_flash_model u_flash (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .ecc(ecc),
      .arr_req(arr_req), .arr_ready(arr_ready), .arr_rsp(arr_rsp));
   task check(input logic [65:0] seen, input logic [65:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One read held until taken, then its single answer judged
   task automatic xfer(input logic p, input logic [2:0] m, input logic [23:0] a, input logic rf);
      int n;
      @(negedge sys_clk) req[p] = '{1'b1, m, a};
      while (rdy[p] !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk) req[p].valid = 1'b0;
      for (n = 0; n < 30 && rsp[p].valid !== 1'b1; n++) @(negedge sys_clk);
      last_p = p;
      check({rsp[p].valid, rsp[p].error, rsp[p].data}, {1'b1, rf || ecc != 2'h0, rf ? 64'h0 : {40'h0, a}});
   endtask
   task automatic clash(input logic loser);
      fork
         xfer(1'b0, 3'h1, 24'h000111, 1'b0);
         xfer(1'b1, 3'h6, 24'h000222, 1'b0);
      join
      check({65'h0, last_p}, {65'h0, loser});
   endtask
   task refusals;
      for (int m = 0; m < 8; m++) begin
         xfer(1'b0, m[2:0], {21'h1, m[2:0]}, m > 1);
         xfer(1'b1, m[2:0], {21'h2, m[2:0]}, m < 2);
      end
   endtask
   task ecc_errors;
      for (int e = 1; e < 4; e++) begin
         ecc = e[1:0];
         xfer(1'b1, 3'h5, 24'hABCDE0, 1'b0);
      end
      ecc = 2'h0;
   endtask
   task fixed_prio;
      slow = 1'b1;
      clash(1'b1);
      hi_prio_port = 1'b1;
      clash(1'b0);
   endtask
   // Shared port stays high priority so fixed mode would answer the first clash differently
   task round_robin;
      arb_mode = dpfa_pkg::DPFA_MODE_RR;
      xfer(1'b1, 3'h2, 24'h000333, 1'b0);
      clash(1'b1);
      xfer(1'b0, 3'h0, 24'h000444, 1'b0);
      clash(1'b0);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) rstn = 1'b1;
      refusals;
      ecc_errors;
      fixed_prio;
      round_robin;
      tally_and_finish;
   end
   // Whole run needs a few hundred cycles; 2000 means a hang
   initial begin
      #50000;
      bad_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
